// ==== src/fhc_defines.svh ====
`ifndef FHC_DEFINES_SVH
`define FHC_DEFINES_SVH

// ==========================================================
// Clock and rounding helpers
`define FHC_CLK_NS 25
`define FHC_CYC(ns) ((((ns) + `FHC_CLK_NS - 1) / `FHC_CLK_NS))
`define FHC_MAX(a, b) (((a) > (b)) ? (a) : (b))
`define FHC_SYNC_CYC 2

// ==========================================================
// Pin timing of the buffer, slowest grade, in ns
`define FHC_T_CLR_NS 80
`define FHC_T_RSS_NS 80
`define FHC_T_RSR_NS 20
`define FHC_T_REPLAY_NS 80
`define FHC_T_RTS_NS 80
`define FHC_T_RTR_NS 20
`define FHC_T_WPW_NS 80
`define FHC_T_DS_NS 40
`define FHC_T_DH_NS 10
`define FHC_T_WR_NS 20
`define FHC_T_RPW_NS 80
`define FHC_T_A_NS 80
`define FHC_T_RR_NS 20
`define FHC_T_FLAG_NS 100

// ==========================================================
// Derived cycle counts
`define FHC_RST_LOW_CYC `FHC_CYC(`FHC_MAX(`FHC_T_CLR_NS, `FHC_T_RSS_NS))
`define FHC_REPLAY_LOW_CYC `FHC_CYC(`FHC_MAX(`FHC_T_REPLAY_NS, `FHC_T_RTS_NS))
`define FHC_WR_LOW_CYC `FHC_CYC(`FHC_MAX(`FHC_T_WPW_NS, `FHC_T_DS_NS))
`define FHC_RD_LOW_CYC `FHC_MAX(`FHC_CYC(`FHC_T_RPW_NS), `FHC_CYC(`FHC_T_A_NS) + `FHC_SYNC_CYC)
`define FHC_SETTLE_CYC (`FHC_CYC(`FHC_T_FLAG_NS) + `FHC_SYNC_CYC)

// ==========================================================
// Buffer capacity and data width
`define FHC_DEPTH 256
`define FHC_DW 9

// ==========================================================
// Register offsets (byte addresses)
`define FHC_REG_CMD 8'h00
`define FHC_REG_WDATA 8'h04
`define FHC_REG_RDATA 8'h08
`define FHC_REG_STATUS 8'h0c
`define FHC_REG_CONFIG 8'h10
`define FHC_REG_WCOUNT 8'h14

// ==========================================================
// Field positions
`define FHC_CMD_RESET 0
`define FHC_CMD_REPLAY 1
`define FHC_CMD_READ 3
`define FHC_ST_BUSY 0
`define FHC_ST_DONE 1
`define FHC_ST_SPACE 2
`define FHC_ST_ITEMS 3
`define FHC_ST_MID 4
`define FHC_ST_REFUSED 5
`define FHC_CFG_EXPAND 0
`define FHC_CFG_FIRST 1

// ==========================================================
// Reset values
`define FHC_CONFIG_RST 2'h0

`endif

// ==== src/fhc_pkg.sv ====
`default_nettype none
package fhc_pkg;

    // ==========================================================
    // Pin sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RST_LOW,
        ST_WR_LOW,
        ST_RD_LOW,
        ST_REPLAY_LOW,
        ST_SETTLE
    } fhc_state_t;

endpackage : fhc_pkg

`default_nettype wire

// ==== src/fhc_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module fhc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    // ==========================================================
    // Two-stage synchroniser; first stage feeds only the second
    always_comb
    begin
        meta_d = ce ? d : meta_q;
        q_d = ce ? meta_q : q;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            meta_q <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_q <= meta_d;
            q <= q_d;
        end
    end

endmodule : fhc_sync

`default_nettype wire

// ==== src/fhc_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fhc_defines.svh"

module fhc_ctrl (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic pointer_clear_n,
    output logic load_pulse_n,
    output logic take_pulse_n,
    output logic replay_n,
    output logic chain_in_n,
    output logic [`FHC_DW-1:0] din,
    input wire logic [`FHC_DW-1:0] dout,
    input wire logic no_space_n,
    input wire logic no_items_n,
    input wire logic past_midpoint_n
);

    localparam int CW = 4;
    localparam int WCW = 11;

    // ==========================================================
    // Pin input synchronisers
    logic [`FHC_DW+2:0] pins_s;
    logic [`FHC_DW-1:0] dout_s;
    logic space_s;
    logic items_s;
    logic mid_s;

    fhc_sync #(
        .W(`FHC_DW + 3),
        .INIT({3'h7, 9'h000})
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .d({no_space_n, no_items_n, past_midpoint_n, dout}),
        .q(pins_s)
    );

    assign space_s = pins_s[`FHC_DW+2];
    assign items_s = pins_s[`FHC_DW+1];
    assign mid_s = pins_s[`FHC_DW];
    assign dout_s = pins_s[`FHC_DW-1:0];

    // ==========================================================
    // State
    fhc_pkg::fhc_state_t st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic clr_n_q, clr_n_d;
    logic load_n_q, load_n_d;
    logic take_n_q, take_n_d;
    logic replay_n_q, replay_n_d;
    logic chain_in_n_q, chain_in_n_d;
    logic [`FHC_DW-1:0] din_q, din_d;
    logic [`FHC_DW-1:0] word_q, word_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] cfg_q, cfg_d;
    logic done_q, done_d;
    logic refused_q, refused_d;
    logic [WCW-1:0] wcount_q, wcount_d;

    logic cmd_wr;
    logic data_wr;
    logic refuse;
    logic idle_replay_n;

    // Turns a cycle figure into a down-counter load value
    function automatic logic [CW-1:0] cnt_load(input int cycles);
        cnt_load = CW'(cycles - 1);
    endfunction : cnt_load

    // Reads of the register map; unmapped offsets read zero
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        reg_read = 32'h0000_0000;
        case (a)
            `FHC_REG_RDATA: reg_read = {23'h000000, word_q};
            `FHC_REG_STATUS:
            begin
                reg_read[`FHC_ST_BUSY] = (st_q != fhc_pkg::ST_IDLE);
                reg_read[`FHC_ST_DONE] = done_q;
                reg_read[`FHC_ST_SPACE] = space_s;
                reg_read[`FHC_ST_ITEMS] = items_s;
                reg_read[`FHC_ST_MID] = mid_s;
                reg_read[`FHC_ST_REFUSED] = refused_q;
            end
            `FHC_REG_CONFIG: reg_read = {30'h00000000, cfg_q};
            `FHC_REG_WCOUNT: reg_read = {21'h000000, wcount_q};
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction : reg_read

    assign cmd_wr = wr && (addr == `FHC_REG_CMD);
    assign data_wr = wr && (addr == `FHC_REG_WDATA);

    // Shared pin idles as first-device mark in a chain, else replay high
    assign idle_replay_n = cfg_q[`FHC_CFG_EXPAND] ? !cfg_q[`FHC_CFG_FIRST] : 1'b1;

    // ==========================================================
    // Next-state logic of sequencer and registers
    always_comb
    begin
        st_d = st_q;
        cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q; // Timed states count down to zero
        clr_n_d = clr_n_q;
        load_n_d = load_n_q;
        take_n_d = take_n_q;
        replay_n_d = replay_n_q;
        chain_in_n_d = cfg_q[`FHC_CFG_EXPAND];
        din_d = din_q;
        word_d = word_q;
        cfg_d = cfg_q;
        done_d = done_q;
        wcount_d = wcount_q;
        refuse = 1'b0;
        rdata_d = rd ? reg_read(addr) : 32'h0000_0000;

        if (wr && (addr == `FHC_REG_CONFIG))
        begin
            cfg_d = wdata[1:0];
        end

        case (st_q)
            fhc_pkg::ST_IDLE:
            begin
                replay_n_d = idle_replay_n;
                if (cmd_wr && wdata[`FHC_CMD_RESET])
                begin
                    // Strobes are already high, so holding the clear low
                    // for the longer of width and set-up covers both
                    clr_n_d = 1'b0;
                    done_d = 1'b0;
                    wcount_d = '0;
                    cnt_d = cnt_load(`FHC_RST_LOW_CYC);
                    st_d = fhc_pkg::ST_RST_LOW;
                end
                else if (cmd_wr && wdata[`FHC_CMD_REPLAY])
                begin
                    if (!done_q || cfg_q[`FHC_CFG_EXPAND]
                        || (wcount_q >= WCW'(`FHC_DEPTH)))
                    begin
                        refuse = 1'b1;
                    end
                    else
                    begin
                        replay_n_d = 1'b0;
                        cnt_d = cnt_load(`FHC_REPLAY_LOW_CYC);
                        st_d = fhc_pkg::ST_REPLAY_LOW;
                    end
                end
                else if (cmd_wr && wdata[`FHC_CMD_READ])
                begin
                    // Host watches the empty flag rather than strobing blind
                    if (!done_q || !items_s)
                    begin
                        refuse = 1'b1;
                    end
                    else
                    begin
                        take_n_d = 1'b0;
                        cnt_d = cnt_load(`FHC_RD_LOW_CYC);
                        st_d = fhc_pkg::ST_RD_LOW;
                    end
                end
                else if (data_wr)
                begin
                    if (!done_q || !space_s)
                    begin
                        refuse = 1'b1;
                    end
                    else
                    begin
                        din_d = wdata[`FHC_DW-1:0];
                        load_n_d = 1'b0;
                        cnt_d = cnt_load(`FHC_WR_LOW_CYC);
                        st_d = fhc_pkg::ST_WR_LOW;
                    end
                end
            end
            fhc_pkg::ST_RST_LOW:
            begin
                if (cnt_q == '0)
                begin
                    clr_n_d = 1'b1;
                    done_d = 1'b1;
                    cnt_d = cnt_load(`FHC_SETTLE_CYC);
                    st_d = fhc_pkg::ST_SETTLE;
                end
            end
            fhc_pkg::ST_WR_LOW:
            begin
                if (cnt_q == '0)
                begin
                    // Rising edge latches din; din stays put through settle
                    load_n_d = 1'b1;
                    if (wcount_q != {WCW{1'b1}})
                    begin
                        wcount_d = wcount_q + 1'b1;
                    end
                    cnt_d = cnt_load(`FHC_SETTLE_CYC);
                    st_d = fhc_pkg::ST_SETTLE;
                end
            end
            fhc_pkg::ST_RD_LOW:
            begin
                if (cnt_q == '0)
                begin
                    // Sample before the rise: the output floats afterwards
                    word_d = dout_s;
                    take_n_d = 1'b1;
                    cnt_d = cnt_load(`FHC_SETTLE_CYC);
                    st_d = fhc_pkg::ST_SETTLE;
                end
            end
            fhc_pkg::ST_REPLAY_LOW:
            begin
                if (cnt_q == '0)
                begin
                    replay_n_d = 1'b1;
                    cnt_d = cnt_load(`FHC_SETTLE_CYC);
                    st_d = fhc_pkg::ST_SETTLE;
                end
            end
            fhc_pkg::ST_SETTLE:
            begin
                // Covers recovery times and flag delay plus synchroniser
                if (cnt_q == '0)
                begin
                    st_d = fhc_pkg::ST_IDLE;
                end
            end
            default:
            begin
                st_d = fhc_pkg::ST_IDLE;
            end
        endcase

        // Any command arriving while busy is refused too
        if ((st_q != fhc_pkg::ST_IDLE) && (cmd_wr || data_wr))
        begin
            refuse = 1'b1;
        end

        // New refusal wins over a clear in the same cycle
        refused_d = (refused_q && !(wr && (addr == `FHC_REG_STATUS)
                     && wdata[`FHC_ST_REFUSED])) || refuse;
    end

    // ==========================================================
    // Registers; clock enable low freezes everything
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_q <= fhc_pkg::ST_IDLE;
            cnt_q <= '0;
            clr_n_q <= 1'b1;
            load_n_q <= 1'b1;
            take_n_q <= 1'b1;
            replay_n_q <= 1'b1;
            chain_in_n_q <= 1'b0;
            din_q <= '0;
            word_q <= '0;
            rdata_q <= 32'h0000_0000;
            cfg_q <= `FHC_CONFIG_RST;
            done_q <= 1'b0;
            refused_q <= 1'b0;
            wcount_q <= '0;
        end
        else if (ce)
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            clr_n_q <= clr_n_d;
            load_n_q <= load_n_d;
            take_n_q <= take_n_d;
            replay_n_q <= replay_n_d;
            chain_in_n_q <= chain_in_n_d;
            din_q <= din_d;
            word_q <= word_d;
            rdata_q <= rdata_d;
            cfg_q <= cfg_d;
            done_q <= done_d;
            refused_q <= refused_d;
            wcount_q <= wcount_d;
        end
    end

    // ==========================================================
    // Outputs straight from flip-flops
    assign rdata = rdata_q;
    assign pointer_clear_n = clr_n_q;
    assign load_pulse_n = load_n_q;
    assign take_pulse_n = take_n_q;
    assign replay_n = replay_n_q;
    assign chain_in_n = chain_in_n_q;
    assign din = din_q;

endmodule : fhc_ctrl

`default_nettype wire

// ==== verif/fhc_ctrl_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fhc_defines.svh"
// ====================
// Pin sequencing checks
module fhc_ctrl_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic pointer_clear_n,
    input wire logic load_pulse_n,
    input wire logic take_pulse_n,
    input wire logic replay_n,
    input wire logic chain_in_n,
    input wire logic [`FHC_DW-1:0] din,
    input wire logic no_space_n,
    input wire logic no_items_n
);
    // One clock for every check; frozen cycles would stretch every count
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn || !ce);
    // Low times of the strobes, in system cycles
    clear_width_a: assert property ($fell(pointer_clear_n) |->
        (!pointer_clear_n)[*4] ##1 pointer_clear_n) else $error("clear width");
    load_width_a: assert property ($fell(load_pulse_n) |->
        (!load_pulse_n)[*4] ##1 load_pulse_n) else $error("load width");
    take_width_a: assert property ($fell(take_pulse_n) |->
        (!take_pulse_n)[*6] ##1 take_pulse_n) else $error("take width");
    replay_width_a: assert property ($fell(replay_n) && !chain_in_n |->
        (!replay_n)[*4] ##1 replay_n) else $error("replay width");
    // Data strobes stay quiet through a clear or replay and its recovery
    strobe_quiet_a: assert property ((!pointer_clear_n || !replay_n && !chain_in_n) |->
        (load_pulse_n && take_pulse_n)[*6]) else $error("strobe during clear");
    // A settled full or empty flag blocks the matching strobe
    full_block_a: assert property ((!no_space_n)[*8] |-> load_pulse_n)
        else $error("write while full");
    empty_block_a: assert property ((!no_items_n)[*8] |-> take_pulse_n)
        else $error("read while empty");
    // Write data only moves when a write starts, so it holds over the rising edge
    din_hold_a: assert property (!$fell(load_pulse_n) |-> $stable(din))
        else $error("din moved");
endmodule : fhc_ctrl_sva

bind fhc_ctrl fhc_ctrl_sva chk (.clk, .resetn, .ce, .pointer_clear_n, .load_pulse_n,
    .take_pulse_n, .replay_n, .chain_in_n, .din, .no_space_n, .no_items_n);
`default_nettype wire

// ==== verif/fhc_fifo_model.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fhc_defines.svh"
// ====================
// Behavioural buffer at the controller's pins
module fhc_fifo_model (
    input wire logic pointer_clear_n,
    input wire logic load_pulse_n,
    input wire logic take_pulse_n,
    input wire logic replay_n,
    input wire logic chain_in_n,
    input wire logic [`FHC_DW-1:0] din,
    output logic [`FHC_DW-1:0] dout,
    output logic no_space_n,
    output logic no_items_n,
    output logic past_midpoint_n
);
    logic [`FHC_DW-1:0] mem [`FHC_DEPTH];
    int wp = 0;
    int rp = 0;
    bit wr_ok = 1'b0;
    bit rd_ok = 1'b0;
    // Pointers count without limit; flags come from their distance
    assign no_items_n = (wp != rp);
    assign no_space_n = (wp - rp != `FHC_DEPTH);
    // Known start for the released bus and half flag
    initial
    begin
        dout = '0;
        past_midpoint_n = 1'b1;
    end
    // Clear holds both pointers at the first location
    always @(pointer_clear_n)
        if (pointer_clear_n === 1'b0)
        begin
            wp = 0;
            rp = 0;
            past_midpoint_n = 1'b1;
        end
    // Write armed on the fall only with space left, stored on the rise
    always @(negedge load_pulse_n)
    begin
        wr_ok = pointer_clear_n && no_space_n;
        if (wr_ok && wp - rp >= `FHC_DEPTH / 2)
            past_midpoint_n = 1'b0;
    end
    always @(posedge load_pulse_n)
        if (wr_ok)
        begin
            mem[wp % `FHC_DEPTH] = din;
            wp++;
            wr_ok = 1'b0;
        end
    // Read armed on the fall only with data; a released bus shows the inverse
    always @(negedge take_pulse_n)
    begin
        rd_ok = pointer_clear_n && no_items_n;
        dout = rd_ok ? mem[rp % `FHC_DEPTH] : ~dout;
    end
    always @(posedge take_pulse_n)
    begin
        dout = ~dout;
        if (rd_ok)
            rp++;
        if (rd_ok && wp - rp <= `FHC_DEPTH / 2)
            past_midpoint_n = 1'b1;
        rd_ok = 1'b0;
    end
    // Replay only in single mode; the shared pin is ignored when chained
    always @(posedge replay_n)
        if (chain_in_n === 1'b0 && pointer_clear_n === 1'b1)
        begin
            rp = 0;
            past_midpoint_n = (wp <= `FHC_DEPTH / 2);
        end
endmodule : fhc_fifo_model
`default_nettype wire

// ==== verif/fhc_ctrl_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fhc_defines.svh"
// ====================
// Bench: controller driving a behavioural buffer
module fhc_ctrl_test;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic pointer_clear_n, load_pulse_n, take_pulse_n, replay_n, chain_in_n;
    logic no_space_n, no_items_n, past_midpoint_n;
    logic [`FHC_DW-1:0] din, dout;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int wq[$];
    int ri = 0;
    bit done_m = 1'b0;
    bit refused_m = 1'b0;
    bit expand_m = 1'b0;
    int cfg[4] = '{1, 3, 1, 0};

    fhc_ctrl dut (.clk, .resetn, .ce, .addr, .wdata, .wr, .rd, .rdata, .pointer_clear_n,
        .load_pulse_n, .take_pulse_n, .replay_n, .chain_in_n, .din, .dout, .no_space_n,
        .no_items_n, .past_midpoint_n);
    fhc_fifo_model far_end (.pointer_clear_n, .load_pulse_n, .take_pulse_n, .replay_n,
        .chain_in_n, .din, .dout, .no_space_n, .no_items_n, .past_midpoint_n);

    // Clock, and a ceiling well above the roughly 10000 cycles needed
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    // Bus cycles: strobes one cycle long, read data only in the next cycle
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask : bus_rd

    // Launch a command, then poll with a bound until the sequencer is idle
    task automatic op(input logic [7:0] a, input logic [31:0] v);
        bus_wr(a, v);
        for (int i = 0; i < 40; i++)
        begin
            bus_rd(`FHC_REG_STATUS, d);
            if (d[`FHC_ST_BUSY] === 1'b0)
                break;
        end
    endtask : op

    // Status against the bench's own account, then clear any refusal
    task automatic chk_stat();
        int n;
        n = wq.size() - ri;
        bus_rd(`FHC_REG_STATUS, d);
        chk_word(d & 32'h3f, {26'h0, refused_m, (n <= `FHC_DEPTH / 2), (n != 0),
            (n != `FHC_DEPTH), done_m, 1'b0});
        if (refused_m)
            bus_wr(`FHC_REG_STATUS, 32'h20);
        refused_m = 1'b0;
    endtask : chk_stat

    // Commands, each accepted or refused as the buffer state allows
    task automatic do_write(input logic [31:0] v);
        bit ok;
        ok = done_m && wq.size() - ri < `FHC_DEPTH;
        op(`FHC_REG_WDATA, v);
        if (ok)
            wq.push_back(v);
        refused_m = !ok;
        chk_stat();
    endtask : do_write
    task automatic do_read();
        bit ok;
        ok = done_m && wq.size() > ri;
        op(`FHC_REG_CMD, 32'h8);
        refused_m = !ok;
        if (ok)
            bus_rd(`FHC_REG_RDATA, d);
        if (ok)
            chk_word(d, wq[ri]);
        if (ok)
            ri++;
        chk_stat();
    endtask : do_read
    task automatic do_replay();
        bit ok;
        ok = done_m && !expand_m && wq.size() < `FHC_DEPTH;
        op(`FHC_REG_CMD, 32'h2);
        refused_m = !ok;
        if (ok)
            ri = 0;
        chk_stat();
    endtask : do_replay
    task automatic do_reset();
        op(`FHC_REG_CMD, 32'h1);
        done_m = 1'b1;
        wq.delete();
        ri = 0;
        chk_stat();
    endtask : do_reset

    // Main sequence
    initial
    begin
        void'($urandom(71));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        do_write(32'h1a5);
        do_read();
        do_reset();
        do_read();
        bus_wr(`FHC_REG_WDATA, 32'h1a5);
        wq.push_back(32'h1a5);
        op(`FHC_REG_WDATA, 32'h0ff);
        refused_m = 1'b1;
        chk_stat();
        repeat (3) do_write($urandom & 32'h1ff);
        repeat (2) do_read();
        do_replay();
        do_read();
        while (wq.size() - ri < `FHC_DEPTH)
            do_write($urandom & 32'h1ff);
        do_write(32'h155);
        do_read();
        do_write($urandom & 32'h1ff);
        do_replay();
        while (wq.size() > ri)
            do_read();
        do_read();
        do_reset();
        do_write(32'h0c3);
        do_read();
        foreach (cfg[i])
        begin
            bus_wr(`FHC_REG_CONFIG, cfg[i]);
            expand_m = cfg[i][0];
            bus_rd(`FHC_REG_CONFIG, d);
            chk_word(d, cfg[i]);
            chk_word({31'h0, chain_in_n}, {31'h0, expand_m});
            do_replay();
        end
        do_read();
        // Clock enable low mid-write holds the strobe low past its usual width
        bus_wr(`FHC_REG_WDATA, 32'h03c);
        wq.push_back(32'h03c);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        chk_word({31'h0, load_pulse_n}, 32'h0);
        ce <= 1'b1;
        op(8'h20, 32'h0);
        chk_stat();
        do_read();
        bus_rd(8'h20, d);
        chk_word(d, 32'h0);
        finish_test();
    end
endmodule : fhc_ctrl_test
`default_nettype wire
